// ==== ftm_pkg.sv ====
package ftm_pkg;
    // ========================================
    // register map
    localparam logic [7:0] FTM_REG_CTRL = 8'h34;
    localparam logic [7:0] FTM_REG_THR  = 8'h35;
    localparam logic [7:0] FTM_REG_CUR  = 8'h36;
    // control field positions
    localparam int FTM_EN_BIT  = 7;
    localparam int FTM_IE_BIT  = 6;
    localparam int FTM_DIV_LSB = 0;
    localparam int FTM_DIV_W   = 2;
    // ========================================
    // reset values and count limits
    localparam logic [7:0] FTM_ZERO    = 8'h00;
    localparam logic [7:0] FTM_CNT_MAX = 8'hFF;
    localparam logic [7:0] FTM_THR_RST = 8'h00;
    // ========================================
    // timing
    localparam int FTM_CLK_HZ  = 50_000_000;
    localparam int FTM_TB_HZ   = 20_000;
    localparam int FTM_TB_CYC  = FTM_CLK_HZ / FTM_TB_HZ;
    localparam int FTM_TB_W    = 12;
    localparam int FTM_FILT_NS = 10_000;
    localparam int FTM_FILT_CYC =
        (FTM_FILT_NS * (FTM_CLK_HZ / 1_000_000) + 999) / 1000;
    // ========================================
    // measurement phase
    typedef enum logic [1:0] {
        FTM_PH_IDLE,
        FTM_PH_ARM,
        FTM_PH_MEAS
    } ftm_phase_t;
endpackage

// ==== ftm_tach_filter.sv ====
`timescale 1ns/100ps
module ftm_tach_filter #(
    parameter int FILT_CYC = ftm_pkg::FTM_FILT_CYC,
    parameter int CW       = 10
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // raw tachometer level
    input  wire logic pin_i,
    // conditioned outputs
    output logic      level,
    output logic      rise
);
    typedef struct packed {
        logic          s1;
        logic          s2;
        logic          stable;
        logic [CW-1:0] cnt;
        logic          rise;
    } ftm_filt_t;

    ftm_filt_t q_r, q_nxt;

    initial begin
        if (FILT_CYC < 1 || FILT_CYC >= (1 << CW)) begin
            $error("filter length does not fit counter");
        end
    end

    // ========================================
    // sync then debounce: a slow edge must hold
    // steady for the full window before it counts
    always_comb begin
        q_nxt      = q_r;
        q_nxt.s1   = pin_i;
        q_nxt.s2   = q_r.s1;
        q_nxt.rise = 1'b0;
        if (q_r.s2 == q_r.stable) begin
            q_nxt.cnt = '0;
        end else if (q_r.cnt == CW'(FILT_CYC - 1)) begin
            q_nxt.stable = q_r.s2;
            q_nxt.rise   = q_r.s2;
            q_nxt.cnt    = '0;
        end else begin
            q_nxt.cnt = q_r.cnt + CW'(1);
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign level = q_r.stable;
    assign rise  = q_r.rise;

    // a rise is only ever one cycle long
    property p_rise_pulse;
        @(posedge clk) disable iff (rst)
        rise |=> !rise;
    endproperty
    a_rise_pulse: assert property (p_rise_pulse)
        else $error("filtered rise longer than one cycle");
endmodule

// ==== ftm_channel.sv ====
`timescale 1ns/100ps
module ftm_channel #(
    parameter int TB_CYC   = ftm_pkg::FTM_TB_CYC,
    parameter int FILT_CYC = ftm_pkg::FTM_FILT_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // register port from serial slave
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // interrupt
    input  wire logic       irq_clear,
    output logic            irq_n,
    output logic [7:0]      irq_source_register,
    // pin configuration from elsewhere
    input  wire logic       bypass_sel,
    input  wire logic       bypass_out,
    input  wire logic       gpio_o,
    input  wire logic       gpio_oe,
    // pin
    input  wire logic       tach_input_pin_i,
    output logic            tach_input_pin_o,
    output logic            tach_input_pin_oe
);
    localparam int TBW = ftm_pkg::FTM_TB_W;

    typedef struct packed {
        ftm_pkg::ftm_phase_t  ph;
        logic                 tach_channel_enable;
        logic                 tach_irq_enable;
        logic [1:0]           tach_divisor_select;
        logic [7:0]           thr;
        logic [7:0]           cur;
        logic [7:0]           cnt;
        logic [TBW-1:0]       tb;
        logic [2:0]           dv;
        logic                 half;
        logic                 pend;
        logic [7:0]           src;
        logic [7:0]           rdata;
    } ftm_state_t;

    ftm_state_t q_r, q_nxt;
    logic       tach_level;
    logic       tach_rise;
    logic       tick;
    logic       inc;
    logic       edge_ok;
    logic       cond;
    logic       frozen;
    logic       rev_done;

    initial begin
        if (TB_CYC < 4 || TB_CYC >= (1 << TBW)) begin
            $error("time base count does not fit");
        end
    end

    // divisor code to index of the last tick of each count (ticks per count minus one)
    function automatic logic [2:0] ftm_div_last(input logic [1:0] sel);
        logic [3:0] d;
        d = 4'h1 << sel;
        return 3'(d - 4'h1);
    endfunction

    // ========================================
    // input conditioning
    ftm_tach_filter #(
        .FILT_CYC (FILT_CYC)
    ) ftm_tach_filter_inst (
        .clk   (clk),
        .rst   (rst),
        .pin_i (tach_input_pin_i),
        .level (tach_level),
        .rise  (tach_rise)
    );

    // ========================================
    // pin ownership: bypass beats fan input,
    // fan input beats every other setting
    always_comb begin
        if (q_r.tach_channel_enable && bypass_sel) begin
            tach_input_pin_oe = 1'b1;
            tach_input_pin_o  = bypass_out;
        end else if (q_r.tach_channel_enable) begin
            tach_input_pin_oe = 1'b0;
            tach_input_pin_o  = 1'b0;
        end else begin
            tach_input_pin_oe = gpio_oe;
            tach_input_pin_o  = gpio_o;
        end
    end

    // ========================================
    // measurement helpers
    assign tick     = (q_r.tb == TBW'(TB_CYC - 1));
    assign inc      = tick &&
                      (q_r.dv == ftm_div_last(q_r.tach_divisor_select));
    assign edge_ok  = tach_rise && !bypass_sel;
    assign rev_done = edge_ok && q_r.ph == ftm_pkg::FTM_PH_MEAS
                      && q_r.half;
    // frozen only while an enabled irq is pending
    assign frozen   = q_r.pend && q_r.tach_irq_enable;
    assign cond     = q_r.tach_channel_enable && q_r.tach_irq_enable
                      && q_r.ph != ftm_pkg::FTM_PH_IDLE
                      && q_r.cnt >= q_r.thr;

    // ========================================
    // next state
    always_comb begin
        q_nxt = q_r;
        // free running 20 kHz time base
        q_nxt.tb = tick ? '0 : q_r.tb + TBW'(1);
        if (tick) begin
            q_nxt.dv = inc ? 3'h0 : q_r.dv + 3'h1;
        end
        // saturating tick counter
        if (inc && q_r.cnt != ftm_pkg::FTM_CNT_MAX) begin
            q_nxt.cnt = q_r.cnt + 8'h01;
        end
        case (q_r.ph)
            ftm_pkg::FTM_PH_IDLE: begin
                q_nxt.cnt = ftm_pkg::FTM_ZERO;
                q_nxt.dv  = 3'h0;
                if (q_r.tach_channel_enable) begin
                    q_nxt.ph = ftm_pkg::FTM_PH_ARM;
                end
            end
            ftm_pkg::FTM_PH_ARM: begin
                // first edge opens a revolution
                if (edge_ok) begin
                    q_nxt.ph   = ftm_pkg::FTM_PH_MEAS;
                    q_nxt.cnt  = ftm_pkg::FTM_ZERO;
                    q_nxt.dv   = 3'h0;
                    q_nxt.half = 1'b0;
                end
            end
            ftm_pkg::FTM_PH_MEAS: begin
                if (edge_ok) begin
                    q_nxt.half = !q_r.half;
                end
                // two pulses make one revolution
                if (rev_done) begin
                    q_nxt.cnt = ftm_pkg::FTM_ZERO;
                    q_nxt.dv  = 3'h0;
                    if (!frozen) begin
                        q_nxt.cur = q_r.cnt;
                    end
                end
            end
            default: begin
                q_nxt.ph = ftm_pkg::FTM_PH_IDLE;
            end
        endcase
        // stalled fan shows all ones unless the count is frozen
        if (q_r.ph != ftm_pkg::FTM_PH_IDLE && !frozen
            && q_r.cnt == ftm_pkg::FTM_CNT_MAX) begin
            q_nxt.cur = ftm_pkg::FTM_CNT_MAX;
        end
        // clear restarts the measurement; a new
        // condition in the same cycle still wins
        if (irq_clear && q_r.pend) begin
            q_nxt.pend = 1'b0;
            q_nxt.cur  = ftm_pkg::FTM_ZERO;
            q_nxt.cnt  = ftm_pkg::FTM_ZERO;
            q_nxt.dv   = 3'h0;
            if (q_r.ph != ftm_pkg::FTM_PH_IDLE) begin
                q_nxt.ph = ftm_pkg::FTM_PH_ARM;
            end
        end
        if (cond) begin
            q_nxt.pend = 1'b1;
            q_nxt.src  = ftm_pkg::FTM_REG_CTRL;
        end
        // disabling drops all channel activity
        if (!q_r.tach_channel_enable) begin
            q_nxt.ph   = ftm_pkg::FTM_PH_IDLE;
            q_nxt.pend = 1'b0;
            q_nxt.cur  = ftm_pkg::FTM_ZERO;
        end
        // register writes; reserved bits not stored
        if (reg_wr) begin
            case (reg_addr)
                ftm_pkg::FTM_REG_CTRL: begin
                    q_nxt.tach_channel_enable =
                        reg_wdata[ftm_pkg::FTM_EN_BIT];
                    q_nxt.tach_irq_enable =
                        reg_wdata[ftm_pkg::FTM_IE_BIT];
                    q_nxt.tach_divisor_select = reg_wdata[
                        ftm_pkg::FTM_DIV_LSB +: ftm_pkg::FTM_DIV_W];
                end
                ftm_pkg::FTM_REG_THR: begin
                    q_nxt.thr = reg_wdata;
                end
                default: begin
                    q_nxt.thr = q_r.thr; // count is read-only
                end
            endcase
        end
        // registered read data, zero if unmapped
        if (reg_rd) begin
            case (reg_addr)
                ftm_pkg::FTM_REG_CTRL: begin
                    q_nxt.rdata = ftm_pkg::FTM_ZERO;
                    q_nxt.rdata[ftm_pkg::FTM_EN_BIT] =
                        q_r.tach_channel_enable;
                    q_nxt.rdata[ftm_pkg::FTM_IE_BIT] =
                        q_r.tach_irq_enable;
                    q_nxt.rdata[ftm_pkg::FTM_DIV_LSB +:
                        ftm_pkg::FTM_DIV_W] = q_r.tach_divisor_select;
                end
                ftm_pkg::FTM_REG_THR: begin
                    q_nxt.rdata = q_r.thr;
                end
                ftm_pkg::FTM_REG_CUR: begin
                    q_nxt.rdata = q_r.cur;
                end
                default: begin
                    q_nxt.rdata = ftm_pkg::FTM_ZERO;
                end
            endcase
        end
    end

    // ========================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r       <= '0;
            q_r.ph    <= ftm_pkg::FTM_PH_IDLE;
            q_r.thr   <= ftm_pkg::FTM_THR_RST;
            q_r.cur   <= ftm_pkg::FTM_ZERO;
        end else begin
            q_r <= q_nxt;
        end
    end

    // outputs straight from the state
    assign reg_rdata           = q_r.rdata;
    assign irq_n               = !q_r.pend;
    assign irq_source_register = q_r.src;

    // ========================================
    // checks
    property p_irq_set;
        @(posedge clk) disable iff (rst)
        cond |=> (!irq_n && irq_source_register == ftm_pkg::FTM_REG_CTRL);
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("irq condition did not assert irq");

    property p_no_irq;
        @(posedge clk) disable iff (rst)
        (!q_r.tach_irq_enable && q_r.pend == 1'b0 && !reg_wr)
            |=> irq_n;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("irq raised with irq enable clear");

    property p_hold;
        @(posedge clk) disable iff (rst)
        (frozen && !irq_clear && q_r.tach_channel_enable && !reg_wr)
            |=> $stable(q_r.cur);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved while irq pending");

    property p_clear;
        @(posedge clk) disable iff (rst)
        (irq_clear && q_r.pend && !cond) |=>
            (q_r.cur == 8'h00 && irq_n);
    endproperty
    a_clear: assert property (p_clear)
        else $error("irq clear did not zero count");

    property p_disabled_pin;
        @(posedge clk) disable iff (rst)
        !q_r.tach_channel_enable |->
            (tach_input_pin_oe == gpio_oe && tach_input_pin_o == gpio_o);
    endproperty
    a_disabled_pin: assert property (p_disabled_pin)
        else $error("disabled channel touched pin");

    property p_bypass;
        @(posedge clk) disable iff (rst)
        (q_r.tach_channel_enable && bypass_sel) |->
            (tach_input_pin_oe && tach_input_pin_o == bypass_out);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass did not drive pin");

    property p_sat;
        @(posedge clk) disable iff (rst)
        (q_r.cnt == 8'hFF && !rev_done && !irq_clear && !edge_ok
         && q_r.tach_channel_enable && !reg_wr) |=> q_r.cnt == 8'hFF;
    endproperty
    a_sat: assert property (p_sat)
        else $error("counter wrapped");

    property p_stall;
        @(posedge clk) disable iff (rst)
        (q_r.cnt == 8'hFF && q_r.ph != ftm_pkg::FTM_PH_IDLE && !frozen
         && !irq_clear && q_r.tach_channel_enable && !reg_wr)
            |=> q_r.cur == 8'hFF;
    endproperty
    a_stall: assert property (p_stall)
        else $error("stalled fan not shown as FFh");

    property p_publish;
        @(posedge clk) disable iff (rst)
        (rev_done && !frozen && !irq_clear && q_r.cnt != 8'hFF
         && q_r.tach_channel_enable && !reg_wr)
            |=> q_r.cur == $past(q_r.cnt);
    endproperty
    a_publish: assert property (p_publish)
        else $error("revolution did not refresh count");

    property p_thr_rw;
        @(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == ftm_pkg::FTM_REG_THR) ##1 !reg_wr
            ##1 (reg_rd && reg_addr == ftm_pkg::FTM_REG_THR)
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_thr_rw: assert property (p_thr_rw)
        else $error("threshold readback mismatch");

    property p_tick_rate;
        @(posedge clk) disable iff (rst)
        tick |=> !tick [*3];
    endproperty
    a_tick_rate: assert property (p_tick_rate)
        else $error("time base ticks too fast");

    property p_first_zero;
        @(posedge clk) disable iff (rst)
        (q_r.ph == ftm_pkg::FTM_PH_ARM && q_nxt.ph == ftm_pkg::FTM_PH_ARM
         && $past(q_r.ph) == ftm_pkg::FTM_PH_IDLE)
            |-> q_r.cur == 8'h00;
    endproperty
    a_first_zero: assert property (p_first_zero)
        else $error("count not zero before first revolution");
endmodule

// ==== ftm_fan_model.sv ====
`timescale 1ns/100ps
// ========================================
// fan tachometer: two pulses per turn, square wave
module ftm_fan_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // control from the bench
    input  wire logic        run,
    input  wire logic        bounce,
    input  wire logic [15:0] half_cyc,
    // tachometer output
    output logic             tach_o
);
    logic [15:0] cnt_r;
    logic        lvl_r;

    // half period counter; a stalled fan rests low, never pulsing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            lvl_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= 16'h0000;
            lvl_r <= 1'b0;
        end else if (cnt_r >= half_cyc - 16'h0001) begin
            cnt_r <= 16'h0000;
            lvl_r <= !lvl_r;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // bounce: a one-cycle dip shortly after each rise, like a slow edge
    assign tach_o = lvl_r & !(bounce && cnt_r == 16'h0003);
endmodule

// ==== ftm_channel_tb.sv ====
`timescale 1ns/100ps
module ftm_channel_tb;
    // ========================================
    // short counts keep the run brief
    localparam int TB_CYC   = 4;
    localparam int FILT_CYC = 2;
    localparam int LIMIT    = 90000;
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        irq_clear;
    logic        irq_n;
    logic [7:0]  irq_source_register;
    logic        bypass_sel;
    logic        bypass_out;
    logic        gpio_o;
    logic        gpio_oe;
    logic        pin_lvl;
    logic        tach_input_pin_o;
    logic        tach_input_pin_oe;
    logic        fan_run;
    logic        fan_bounce;
    logic [15:0] fan_half;
    logic        fan_tach;
    logic [7:0]  v1;
    logic [7:0]  v2;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;

    ftm_channel #(.TB_CYC(TB_CYC), .FILT_CYC(FILT_CYC)) ftm_channel_inst (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_clear(irq_clear), .irq_n(irq_n),
        .irq_source_register(irq_source_register),
        .bypass_sel(bypass_sel), .bypass_out(bypass_out),
        .gpio_o(gpio_o), .gpio_oe(gpio_oe), .tach_input_pin_i(pin_lvl),
        .tach_input_pin_o(tach_input_pin_o),
        .tach_input_pin_oe(tach_input_pin_oe));

    ftm_fan_model ftm_fan_model_inst (
        .clk(clk), .rst(rst), .run(fan_run), .bounce(fan_bounce),
        .half_cyc(fan_half), .tach_o(fan_tach));

    // shared pin: whoever is enabled wins, else the fan drives it
    assign pin_lvl = tach_input_pin_oe ? tach_input_pin_o : fan_tach;

    // ========================================
    // clock and hang guard
    always #10 clk = !clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            complete_run();
        end
    end

    // ========================================
    // helpers
    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one tick of slack: time base phase at arming is free
    task automatic check_near(input logic [7:0] seen, input logic [7:0] exp);
        if (seen === exp - 8'h01 || seen === exp + 8'h01) begin
            check(exp, exp);
        end else begin
            check(seen, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
    // poll the current count until a first measurement shows up
    task automatic wait_meas(output logic [7:0] v);
        v = 8'h00;
        for (int i = 0; i < 400 && v === 8'h00; i++) begin
            repeat (50) @(posedge clk);
            reg_read(ftm_pkg::FTM_REG_CUR, v);
        end
    endtask
    task automatic pin_chk(input logic oe, input logic o);
        #1;
        check({7'h00, tach_input_pin_oe}, {7'h00, oe});
        if (oe) begin
            check({7'h00, tach_input_pin_o}, {7'h00, o});
        end
    endtask

    // ========================================
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        irq_clear = 1'b0;
        bypass_sel = 1'b0;
        bypass_out = 1'b0;
        gpio_o = 1'b1;
        gpio_oe = 1'b1;
        fan_run = 1'b0;
        fan_bounce = 1'b0;
        fan_half = 16'd300;
        repeat (4) @(posedge clk);
        rst <= 1'b0;

        // reset values, access kinds, unmapped place
        reg_read(ftm_pkg::FTM_REG_CTRL, v1);
        check(v1, 8'h00);
        reg_read(ftm_pkg::FTM_REG_THR, v1);
        check(v1, ftm_pkg::FTM_THR_RST);
        reg_write(ftm_pkg::FTM_REG_THR, 8'h5A);
        reg_read(ftm_pkg::FTM_REG_THR, v1);
        check(v1, 8'h5A);
        reg_write(ftm_pkg::FTM_REG_CUR, 8'hA5);
        reg_read(ftm_pkg::FTM_REG_CUR, v1);
        check(v1, 8'h00);
        reg_read(8'h37, v1);
        check(v1, 8'h00);
        reg_write(ftm_pkg::FTM_REG_CTRL, 8'h3C);
        reg_read(ftm_pkg::FTM_REG_CTRL, v1);
        check(v1, 8'h00);
        $display("test registers done");

        // pin ownership and inert bits while disabled
        fan_run <= 1'b1;
        reg_write(ftm_pkg::FTM_REG_THR, 8'h00);
        reg_write(ftm_pkg::FTM_REG_CTRL, 8'h43);
        repeat (2000) @(posedge clk);
        pin_chk(1'b1, 1'b1);
        check({7'h00, irq_n}, 8'h01);
        reg_write(ftm_pkg::FTM_REG_CTRL, 8'h00);
        fan_run <= 1'b0;
        reg_write(ftm_pkg::FTM_REG_CTRL, 8'h80);
        pin_chk(1'b0, 1'b0);
        @(posedge clk);
        bypass_sel <= 1'b1;
        pin_chk(1'b1, 1'b0);
        @(posedge clk);
        bypass_out <= 1'b1;
        pin_chk(1'b1, 1'b1);
        @(posedge clk);
        bypass_sel <= 1'b0;
        // fan owns the pin from here on; a gpio drive would fake an edge
        gpio_oe <= 1'b0;
        $display("test pin done");

        // every divisor at its nominal speed gives the same count
        for (int d = 0; d < 4; d++) begin
            reg_write(ftm_pkg::FTM_REG_CTRL, 8'h00);
            fan_half <= 16'(150 * (1 << d) * TB_CYC / 4);
            fan_bounce <= (d == 2);
            reg_write(ftm_pkg::FTM_REG_CTRL, 8'h80 | 8'(d));
            reg_read(ftm_pkg::FTM_REG_CUR, v1);
            check(v1, 8'h00);
            fan_run <= 1'b1;
            wait_meas(v1);
            check_near(v1, 8'd150);
        end
        $display("test divisors done");

        // polled refresh follows a speed change
        fan_half <= 16'(100 * 8 * TB_CYC / 4);
        repeat (10000) @(posedge clk);
        reg_read(ftm_pkg::FTM_REG_CUR, v1);
        check_near(v1, 8'd100);
        // stalled fan saturates, no irq with irq enable clear
        reg_write(ftm_pkg::FTM_REG_THR, 8'h10);
        fan_run <= 1'b0;
        repeat (9000) @(posedge clk);
        reg_read(ftm_pkg::FTM_REG_CUR, v1);
        check(v1, ftm_pkg::FTM_CNT_MAX);
        check({7'h00, irq_n}, 8'h01);
        $display("test refresh and stall done");

        // interrupt: threshold first, then enable
        reg_write(ftm_pkg::FTM_REG_CTRL, 8'h00);
        fan_half <= 16'(150 * TB_CYC / 4);
        reg_write(ftm_pkg::FTM_REG_THR, 8'hA0);
        reg_write(ftm_pkg::FTM_REG_CTRL, 8'hC0);
        fan_run <= 1'b1;
        repeat (3000) @(posedge clk);
        check({7'h00, irq_n}, 8'h01);
        fan_half <= 16'(200 * TB_CYC / 4);
        for (int i = 0; i < 3000 && irq_n !== 1'b0; i++) begin
            @(posedge clk);
        end
        #1;
        check({7'h00, irq_n}, 8'h00);
        check(irq_source_register, ftm_pkg::FTM_REG_CTRL);
        reg_read(ftm_pkg::FTM_REG_CUR, v1);
        repeat (2000) @(posedge clk);
        reg_read(ftm_pkg::FTM_REG_CUR, v2);
        check(v2, v1);
        @(posedge clk);
        irq_clear <= 1'b1;
        @(posedge clk);
        irq_clear <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({7'h00, irq_n}, 8'h01);
        reg_read(ftm_pkg::FTM_REG_CUR, v1);
        check(v1, 8'h00);
        $display("test interrupt done");
        complete_run();
    end
endmodule
